// ---- hw/iprr_regs.svh ----
// Constants of the interrupt priority resolver: indices, types, reset values
`ifndef IPRR_REGS_SVH
`define IPRR_REGS_SVH

// Source count and source indices (index is also the default rank)
`define IPRR_NSRC         3'h7
`define IPRR_SRC_TMR      3'h0
`define IPRR_SRC_DMA0     3'h1
`define IPRR_SRC_DMA1     3'h2
`define IPRR_SRC_EXT0     3'h3
`define IPRR_SRC_EXT1     3'h4

// Fixed types handed to the core on acknowledge
`define IPRR_TYPE_TMR0    8'h08
`define IPRR_TYPE_TMR1    8'h12
`define IPRR_TYPE_TMR2    8'h13
`define IPRR_TYPE_DMA0    8'h0A
`define IPRR_TYPE_DMA1    8'h0B
`define IPRR_TYPE_EXT0    8'h0C
`define IPRR_TYPE_EXT1    8'h0D
`define IPRR_TYPE_EXT2    8'h0E
`define IPRR_TYPE_EXT3    8'h0F

// Reset values
`define IPRR_PRIO_RESET   21'h1AC688
`define IPRR_MASK_RESET   7'h7F
`define IPRR_THRESH_RESET 3'h7
`define IPRR_PRIO_LEAST   3'h7

// Timer status bit positions
`define IPRR_TSTAT_T0     2'h0
`define IPRR_TSTAT_T1     2'h1

`endif

// ---- hw/iprr_pkg.sv ----
// Types shared by the interrupt priority resolver modules
package iprr_pkg;

	// One priority value, zero most urgent
	typedef logic [2:0] iprr_prio_t;

	// Priority of every source, index 0 is the timer group
	typedef iprr_prio_t [6:0] iprr_prio_vec_t;

	// Complete state of the top module
	typedef struct packed {
		logic [6:0]     pending;      // Request bits
		logic [6:0]     in_service;   // Handlers in progress
		logic [6:0]     mask;         // One mask bit per source
		iprr_prio_vec_t prio;         // Programmed priorities
		iprr_prio_t     threshold;    // Priority threshold
		logic [3:0]     trigger;      // External pin mode, 1 = level
		logic [1:0]     self_pre;     // Self-preemption, pins 0 and 1
		logic [2:0]     timer_status; // Second-level timer requests
		logic [3:0]     pin_prev;     // Previous pin levels
		logic           int_req;      // Request to the core
		logic [7:0]     int_type;     // Type of last acknowledge
		logic           type_valid;   // Acknowledge produced a type
	} iprr_state_t;

endpackage : iprr_pkg

// ---- hw/iprr_resolver.sv ----
// Combinational qualification and winner selection among pending sources
`timescale 1ns/1ps
`include "iprr_regs.svh"

module iprr_resolver (
	// Source state
	input  wire logic [6:0]             pending,
	input  wire logic [6:0]             mask,
	input  wire logic [6:0]             in_service,
	input  wire iprr_pkg::iprr_prio_vec_t prio,
	// Configuration
	input  wire iprr_pkg::iprr_prio_t   threshold,
	input  wire logic [1:0]             self_pre,
	// Result
	output logic                        q_any,
	output logic [2:0]                  win_idx
);

	// True when a is at least as urgent as b
	function automatic logic iprr_as_urgent(input iprr_pkg::iprr_prio_t a,
		input iprr_pkg::iprr_prio_t b);
		return a <= b;
	endfunction : iprr_as_urgent

	logic [6:0]         qual;      // Sources that meet every criterion
	iprr_pkg::iprr_prio_t floor_p; // Most urgent priority in service
	iprr_pkg::iprr_prio_t best_p;  // Priority of the current winner

	// Nesting floor, then qualification of each source
	always_comb begin
		floor_p = `IPRR_PRIO_LEAST;
		for (int i = 0; i < 7; i++) begin
			if (in_service[i] && prio[i] < floor_p) begin
				floor_p = prio[i];
			end
		end
		for (int i = 0; i < 7; i++) begin
			// RULE_08 request criteria
			qual[i] = pending[i] && !mask[i]
				&& iprr_as_urgent(prio[i], threshold)
				&& iprr_as_urgent(prio[i], floor_p);
			// RULE_12 own service blocks
			if (in_service[i]) begin
				// RULE_19 self preemption exception
				if (!((i == `IPRR_SRC_EXT0 && self_pre[0])
					|| (i == `IPRR_SRC_EXT1 && self_pre[1]))) begin
					qual[i] = 1'b0;
				end
			end
		end
	end

	// Lowest priority value wins; scanning upward keeps ties at lower index
	always_comb begin
		q_any   = 1'b0;
		win_idx = `IPRR_SRC_TMR;
		best_p  = `IPRR_PRIO_LEAST;
		for (int i = 0; i < 7; i++) begin
			// RULE_05 tie keeps default order
			if (qual[i] && (!q_any || prio[i] < best_p)) begin
				q_any   = 1'b1;
				win_idx = 3'(i);
				best_p  = prio[i];
			end
		end
	end

endmodule : iprr_resolver

// ---- hw/iprr_top.sv ----
// Interrupt priority resolver: master-mode request, acknowledge and service tracking
// Operation
// RULE_01 - one mask bit per source blocks it
// RULE_02 - three-bit priority, zero most urgent
// RULE_03 - reset priorities timer 0 to pin3 6
// RULE_04 - timers share source; timer zero favoured
// RULE_05 - equal priorities resolved by default order
// RULE_06 - threshold blocks less urgent; resets to seven
// RULE_07 - detected event sets pending until acknowledged
// RULE_08 - request needs unmasked, threshold, nesting pass
// RULE_09 - core accepts only with global enable
// RULE_10 - acknowledge returns winner at that instant
// RULE_11 - acknowledge clears pending, sets in-service
// RULE_12 - end-of-service clears bit; set bit blocks
// RULE_13 - timer event sets status and shared pending
// RULE_14 - timer acknowledge clears most urgent status
// RULE_15 - shared timer in-service blocks all timers
// RULE_16 - fixed types per source on acknowledge
// RULE_17 - control mask and mask register shared
// RULE_18 - pin trigger select: edge or level
// RULE_19 - pins zero, one may preempt themselves
// RULE_20 - request re-evaluated and dropped each clock
`timescale 1ns/1ps
`include "iprr_regs.svh"

module iprr_top (
	// Clock, reset, enable
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        clk_en,
	// Peripheral events, one-cycle pulses
	input  wire logic [2:0]  timer_event,
	input  wire logic [1:0]  dma_event,
	// External request pins
	input  wire logic        ext_request_pin_0,
	input  wire logic        ext_request_pin_1,
	input  wire logic        ext_request_pin_2,
	input  wire logic        ext_request_pin_3,
	// Mask register view
	input  wire logic        mask_wr,
	input  wire logic [6:0]  mask_wdata,
	// Per-source control write
	input  wire logic        ctl_wr,
	input  wire logic [2:0]  ctl_sel,
	input  wire logic        ctl_mask,
	input  wire logic [2:0]  ctl_prio,
	input  wire logic        trigger_select,
	input  wire logic        ctl_self_pre,
	// Threshold write
	input  wire logic        threshold_wr,
	input  wire logic [2:0]  threshold_wdata,
	// Handler end
	input  wire logic        end_of_service_command,
	input  wire logic [2:0]  eos_source,
	// Core handshake
	input  wire logic        int_ack,
	output logic             int_req,
	output logic [7:0]       int_type,
	output logic             type_valid,
	// Status views
	output logic [6:0]       pending,
	output logic [6:0]       in_service,
	output logic [2:0]       timer_status,
	output logic [6:0]       mask_view,
	output logic [2:0]       threshold_view
);

	iprr_pkg::iprr_state_t st;      // Registered state
	iprr_pkg::iprr_state_t next_st; // Next state
	logic                  q_any;   // Some source qualifies now
	logic [2:0]            win_idx; // Winning source now
	logic [3:0]            pins;    // External pins as a vector
	logic [2:0]            t_clr;   // Timer status bit to clear

	assign pins = {ext_request_pin_3, ext_request_pin_2, ext_request_pin_1, ext_request_pin_0};

	// Most urgent timer among set status bits, one-hot
	function automatic logic [2:0] iprr_lowest(input logic [2:0] t);
		return t & ~3'(t - 3'h1);
	endfunction : iprr_lowest

	// Type handed over for a source; timer type follows its status
	function automatic logic [7:0] iprr_type(input logic [2:0] idx, input logic [2:0] t);
		logic [7:0] ty;
		ty = `IPRR_TYPE_TMR0;
		case (idx)
			3'h0: begin
				if (t[`IPRR_TSTAT_T0]) begin
					ty = `IPRR_TYPE_TMR0;
				end else if (t[`IPRR_TSTAT_T1]) begin
					ty = `IPRR_TYPE_TMR1;
				end else begin
					ty = `IPRR_TYPE_TMR2;
				end
			end
			3'h1: ty = `IPRR_TYPE_DMA0;
			3'h2: ty = `IPRR_TYPE_DMA1;
			3'h3: ty = `IPRR_TYPE_EXT0;
			3'h4: ty = `IPRR_TYPE_EXT1;
			3'h5: ty = `IPRR_TYPE_EXT2;
			3'h6: ty = `IPRR_TYPE_EXT3;
			default: ty = `IPRR_TYPE_TMR0;
		endcase
		return ty;
	endfunction : iprr_type

	// Qualification and winner on the current state
	iprr_resolver u_iprr_resolver (
		.pending    (st.pending),
		.mask       (st.mask),
		.in_service (st.in_service),
		.prio       (st.prio),
		.threshold  (st.threshold),
		.self_pre   (st.self_pre),
		.q_any      (q_any),
		.win_idx    (win_idx)
	);

	// Timer status bit picked at acknowledge
	assign t_clr = iprr_lowest(st.timer_status);

	// Next-state logic; order inside makes event sets win over clears
	always_comb begin
		next_st = st;
		if (clk_en) begin
			next_st.type_valid = 1'b0;
			// RULE_01 whole mask register write
			if (mask_wr) begin
				next_st.mask = mask_wdata;
			end
			// Control write; index outside the sources is ignored
			if (ctl_wr && ctl_sel < `IPRR_NSRC) begin
				// RULE_17 same mask storage
				next_st.mask[ctl_sel] = ctl_mask;
				// RULE_02 programmable priority
				next_st.prio[ctl_sel] = ctl_prio;
				if (ctl_sel >= `IPRR_SRC_EXT0) begin
					next_st.trigger[2'(ctl_sel - `IPRR_SRC_EXT0)] = trigger_select;
				end
				if (ctl_sel == `IPRR_SRC_EXT0 || ctl_sel == `IPRR_SRC_EXT1) begin
					next_st.self_pre[1'(ctl_sel - `IPRR_SRC_EXT0)] = ctl_self_pre;
				end
			end
			// RULE_06 threshold write
			if (threshold_wr) begin
				next_st.threshold = threshold_wdata;
			end
			// RULE_12 end of service
			if (end_of_service_command && eos_source < `IPRR_NSRC) begin
				next_st.in_service[eos_source] = 1'b0;
			end
			// Acknowledge; with nothing qualifying no type is given
			if (int_ack) begin
				if (q_any) begin
					// RULE_10 winner at acknowledge
					// RULE_16 fixed type
					next_st.int_type   = iprr_type(win_idx, st.timer_status);
					next_st.type_valid = 1'b1;
					// RULE_11 pending to in-service
					// RULE_15 shared timer service
					next_st.in_service[win_idx] = 1'b1;
					if (win_idx == `IPRR_SRC_TMR) begin
						// RULE_14 clear one timer status
						next_st.timer_status = st.timer_status & ~t_clr;
						next_st.pending[`IPRR_SRC_TMR] = |(st.timer_status & ~t_clr);
					end else begin
						next_st.pending[win_idx] = 1'b0;
					end
				end
			end
			// RULE_13 timer status and pending
			// RULE_04 timers share one source
			if (|timer_event) begin
				next_st.timer_status = next_st.timer_status | timer_event;
				next_st.pending[`IPRR_SRC_TMR] = 1'b1;
			end
			// RULE_07 events latch pending
			if (dma_event[0]) begin
				next_st.pending[`IPRR_SRC_DMA0] = 1'b1;
			end
			if (dma_event[1]) begin
				next_st.pending[`IPRR_SRC_DMA1] = 1'b1;
			end
			for (int j = 0; j < 4; j++) begin
				// RULE_18 edge or level trigger
				if (st.trigger[j] ? pins[j] : (pins[j] && !st.pin_prev[j])) begin
					next_st.pending[`IPRR_SRC_EXT0 + j] = 1'b1;
				end
			end
			next_st.pin_prev = pins;
			// RULE_20 request follows qualification
			next_st.int_req = q_any;
		end
	end

	// State register with synchronous reset
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st.pending      <= '0;
			st.in_service   <= '0;
			st.mask         <= `IPRR_MASK_RESET;
			// RULE_03 default priorities
			st.prio         <= `IPRR_PRIO_RESET;
			st.threshold    <= `IPRR_THRESH_RESET;
			st.trigger      <= '0;
			st.self_pre     <= '0;
			st.timer_status <= '0;
			st.pin_prev     <= '0;
			st.int_req      <= 1'b0;
			st.int_type     <= `IPRR_TYPE_TMR0;
			st.type_valid   <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from state flip-flops
	assign int_req        = st.int_req;
	assign int_type       = st.int_type;
	assign type_valid     = st.type_valid;
	assign pending        = st.pending;
	assign in_service     = st.in_service;
	assign timer_status   = st.timer_status;
	assign mask_view      = st.mask;
	assign threshold_view = st.threshold;

	// RULE_01 fully masked gives no request
	AST_ALL_MASKED: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_01
		clk_en && (&st.mask) |=> !int_req)
		else $error("request raised with every source masked");

	// RULE_03 reset priorities
	AST_RESET_PRIO: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_03
		$past(sys_rst) |-> st.prio == `IPRR_PRIO_RESET && threshold_view == `IPRR_THRESH_RESET)
		else $error("priorities or threshold wrong after reset");

	// RULE_08 qualified source raises request
	AST_REQ_RAISE: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_08
		clk_en && q_any |=> int_req)
		else $error("qualified source did not raise request");

	// RULE_20 request drops when nothing qualifies
	AST_REQ_DROP: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_20
		clk_en && !q_any |=> !int_req)
		else $error("request held with no qualified source");

	// RULE_11 acknowledge moves DMA0 into service
	AST_ACK_MOVE: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_11
		clk_en && int_ack && q_any && win_idx == `IPRR_SRC_DMA0 && !dma_event[0]
		|=> in_service[1] && !pending[1] && type_valid && int_type == `IPRR_TYPE_DMA0)
		else $error("acknowledge of DMA0 did not move it into service");

	// RULE_14 timer one served, timer two stays
	AST_TIMER_ACK: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_14
		clk_en && int_ack && q_any && win_idx == `IPRR_SRC_TMR
		&& st.timer_status == 3'h6 && timer_event == 3'h0
		|=> timer_status == 3'h4 && pending[0] && int_type == `IPRR_TYPE_TMR1)
		else $error("timer acknowledge handled status wrongly");

	// RULE_15 timer group not served while in service
	AST_TIMER_BLOCK: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_15
		st.in_service[0] |-> !(q_any && win_idx == `IPRR_SRC_TMR))
		else $error("timer won while its service bit was set");

	// RULE_12 end of service clears the bit
	AST_EOS_CLEAR: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_12
		clk_en && end_of_service_command && eos_source == `IPRR_SRC_EXT0 && !int_ack
		|=> !in_service[3])
		else $error("end of service left bit set");

	// RULE_18 edge on pin zero sets pending
	AST_EDGE_PEND: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_18
		clk_en && !st.trigger[0] && ext_request_pin_0 && !st.pin_prev[0]
		|=> pending[3])
		else $error("rising edge on pin zero not latched");

	// RULE_06 threshold blocks less urgent winner
	AST_THRESH: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_06
		q_any |-> st.prio[win_idx] <= st.threshold)
		else $error("winner less urgent than threshold");

	// RULE_08 winner pending and unmasked
	AST_WIN_QUAL: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_08
		q_any |-> st.pending[win_idx] && !st.mask[win_idx])
		else $error("winner not pending or still masked");

	// RULE_12 own service bit blocks
	AST_OWN_BLOCK: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_12
		q_any && st.in_service[win_idx]
		|-> (win_idx == `IPRR_SRC_EXT0 && st.self_pre[0])
		|| (win_idx == `IPRR_SRC_EXT1 && st.self_pre[1]))
		else $error("source won while its own service bit was set");

	// RULE_13 timer zero event latched
	AST_TIMER_SET: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_13
		clk_en && timer_event[0] |=> timer_status[0] && pending[0])
		else $error("timer zero event not latched");

	// RULE_18 level pin keeps pending
	AST_LEVEL_PEND: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_18
		clk_en && st.trigger[2] && ext_request_pin_2 |=> pending[5])
		else $error("level pin two did not keep pending set");

	// RULE_10 type only after acknowledge
	AST_TYPE_ACK: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_10
		clk_en && !int_ack |=> !type_valid)
		else $error("type given without acknowledge");

	// RULE_07 low enable freezes state
	AST_FREEZE: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE_07
		!clk_en |=> $stable(st))
		else $error("state changed with clock enable low");

endmodule : iprr_top

// ---- sim/iprr_core_model.sv ----
// Behavioural processor core: takes the request while its global enable is set
`timescale 1ns/1ps

module iprr_core_model (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// Request side
	input  wire logic        int_req,
	input  wire logic        type_valid,
	input  wire logic [7:0]  int_type,
	// Test controls: global enable, answer delay
	input  wire logic        gie,
	input  wire logic [3:0]  dly,
	// Acknowledge and captured type
	output logic             int_ack,
	output logic [7:0]       got_type,
	output logic [15:0]      got_cnt
);
	logic [3:0] wait_cnt; // Cycles the request has been seen
	logic [2:0] hold;     // Quiet time so a stale request is not taken twice

	// Acknowledge after dly cycles, one pulse per accepted request
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			int_ack <= 1'b0;
			wait_cnt <= 4'h0;
			hold <= 3'h0;
			got_type <= 8'h00;
			got_cnt <= 16'h0000;
		end else begin
			int_ack <= 1'b0;
			// Capture the handed type
			if (type_valid) begin
				got_type <= int_type;
				got_cnt <= got_cnt + 16'h0001;
			end
			if (hold != 3'h0) begin
				hold <= hold - 3'h1;
			end else if (int_req && gie) begin
				wait_cnt <= wait_cnt + 4'h1;
				if (wait_cnt >= dly) begin
					int_ack <= 1'b1;
					wait_cnt <= 4'h0;
					hold <= 3'h6;
				end
			end else begin
				wait_cnt <= 4'h0;
			end
		end
	end

endmodule : iprr_core_model

// ---- sim/tb_iprr_top.sv ----
// Self-checking testbench of the interrupt priority resolver
`timescale 1ns/1ps

module tb_iprr_top;
	// Stimulus
	logic        ref_clk = 1'b0, sys_rst = 1'b1, gie = 1'b0;
	logic [3:0]  dly = 4'h0, pins = 4'h0;
	logic [2:0]  tev = 3'h0, ctl_sel = 3'h0, ctl_prio = 3'h0, thr_d = 3'h7, eos_src = 3'h0;
	logic [1:0]  dev = 2'h0;
	logic        mask_wr = 1'b0, ctl_wr = 1'b0, ctl_mask = 1'b0, trig = 1'b0, sp = 1'b0;
	logic        thr_wr = 1'b0, eos_cmd = 1'b0, clk_en = 1'b1;
	logic [6:0]  mask_wdata = 7'h00;
	// Observed
	logic        int_ack, int_req, type_valid;
	logic [7:0]  int_type, got_type;
	logic [15:0] got_cnt;
	logic [6:0]  pending, in_service, mask_view;
	logic [2:0]  timer_status, threshold_view;
	int          num_errors = 0, samples_checked = 0;

	// Core clock
	always #20 ref_clk = ~ref_clk;

	iprr_top u_iprr_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.timer_event(tev), .dma_event(dev), .ext_request_pin_0(pins[0]),
		.ext_request_pin_1(pins[1]), .ext_request_pin_2(pins[2]), .ext_request_pin_3(pins[3]),
		.mask_wr(mask_wr), .mask_wdata(mask_wdata), .ctl_wr(ctl_wr), .ctl_sel(ctl_sel),
		.ctl_mask(ctl_mask), .ctl_prio(ctl_prio), .trigger_select(trig), .ctl_self_pre(sp),
		.threshold_wr(thr_wr), .threshold_wdata(thr_d), .end_of_service_command(eos_cmd),
		.eos_source(eos_src), .int_ack(int_ack), .int_req(int_req), .int_type(int_type),
		.type_valid(type_valid), .pending(pending), .in_service(in_service),
		.timer_status(timer_status), .mask_view(mask_view), .threshold_view(threshold_view));

	iprr_core_model u_iprr_core_model (.ref_clk(ref_clk), .sys_rst(sys_rst), .int_req(int_req),
		.type_valid(type_valid), .int_type(int_type), .gie(gie), .dly(dly), .int_ack(int_ack),
		.got_type(got_type), .got_cnt(got_cnt));

	// Verdict, reached from the tests and from the watchdog
	task tally_and_finish;
		if (num_errors == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish

	// Compare seen against expected
	task check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Wait edges, then settle past the update
	task tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick

	// Per-source control write
	task ctl(input logic [2:0] s, input logic m, input logic [2:0] p, input logic t, input logic e);
		@(posedge ref_clk);
		{ctl_wr, ctl_sel, ctl_mask, ctl_prio, trig, sp} <= {1'b1, s, m, p, t, e};
		@(posedge ref_clk);
		ctl_wr <= 1'b0;
	endtask : ctl

	// One-cycle events on timers, channels and pins
	task ev(input logic [2:0] t, input logic [1:0] d, input logic [3:0] p);
		@(posedge ref_clk);
		{tev, dev, pins} <= {t, d, p};
		@(posedge ref_clk);
		{tev, dev, pins} <= 9'h000;
	endtask : ev

	// Strobed writes: 0 mask, 1 threshold, 2 end of service
	task wr(input int k, input logic [6:0] v);
		@(posedge ref_clk);
		mask_wr <= (k == 0);
		thr_wr <= (k == 1);
		eos_cmd <= (k == 2);
		{mask_wdata, thr_d, eos_src} <= {v, v[2:0], v[2:0]};
		@(posedge ref_clk);
		{mask_wr, thr_wr, eos_cmd} <= 3'h0;
	endtask : wr

	// Wait for one accepted acknowledge, check type, optionally end service
	task serve(input logic [7:0] t, input logic [2:0] s, input logic e);
		logic [15:0] c;
		int          n;
		c = got_cnt;
		n = 0;
		while (got_cnt == c && n < 80) begin
			@(posedge ref_clk);
			n++;
		end
		#1;
		check(8'(got_cnt != c), 8'h01);
		check(got_type, t);
		if (e) wr(2, 7'(s));
	endtask : serve

	// Serve a list in order, ending each handler
	task seq(input logic [7:0] t[8], input logic [2:0] s[8], input int n);
		for (int i = 0; i < n; i++) serve(t[i], s[i], 1'b1);
	endtask : seq

	// Watchdog cuts a hang short
	initial begin
		#400000;
		num_errors++;
		tally_and_finish();
	end

	// Test sequence
	initial begin
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'b0;
		tick(1);
		check(8'(threshold_view), 8'h07);
		check(8'(mask_view), 8'h7F);
		gie <= 1'b1;
		ev(3'h0, 2'h1, 4'h0);
		tick(3);
		check(8'(pending), 8'h02);
		check(8'(int_req), 8'h00);
		wr(0, 7'h00);
		serve(8'h0A, 3'h1, 1'b0);
		check(8'(in_service), 8'h02);
		check(8'(pending), 8'h00);
		wr(2, 7'h01);
		tick(1);
		check(8'(in_service), 8'h00);
		ctl(3'h4, 1'b1, 3'h4, 1'b0, 1'b0);
		tick(1);
		check(8'(mask_view), 8'h10);
		ctl(3'h4, 1'b0, 3'h4, 1'b0, 1'b0);
		// Everything at once, default priorities
		gie <= 1'b0;
		ev(3'h7, 2'h3, 4'hF);
		tick(2);
		check(8'(pending), 8'h7F);
		check(8'(timer_status), 8'h07);
		gie <= 1'b1;
		serve(8'h08, 3'h0, 1'b0);
		tick(3);
		check(8'(timer_status), 8'h06);
		check(8'(pending), 8'h7F);
		check(8'(int_req), 8'h00);
		wr(2, 7'h00);
		seq('{8'h12, 8'h13, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F},
			'{3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6}, 8);
		// Programmed priorities with ties
		ctl(3'h6, 1'b0, 3'h0, 1'b0, 1'b0);
		ctl(3'h4, 1'b0, 3'h0, 1'b0, 1'b0);
		ctl(3'h1, 1'b0, 3'h2, 1'b0, 1'b0);
		gie <= 1'b0;
		ev(3'h0, 2'h3, 4'hA);
		tick(2);
		gie <= 1'b1;
		seq('{8'h0D, 8'h0F, 8'h0A, 8'h0B, 8'h00, 8'h00, 8'h00, 8'h00},
			'{3'h4, 3'h6, 3'h1, 3'h2, 3'h0, 3'h0, 3'h0, 3'h0}, 4);
		// Winner taken at acknowledge time
		dly <= 4'h6;
		ev(3'h0, 2'h2, 4'h0);
		ev(3'h0, 2'h1, 4'h0);
		serve(8'h0A, 3'h1, 1'b1);
		serve(8'h0B, 3'h2, 1'b1);
		dly <= 4'h0;
		wr(1, 7'h01);
		ev(3'h0, 2'h0, 4'h4);
		tick(4);
		check(8'(threshold_view), 8'h01);
		check(8'(int_req), 8'h00);
		wr(1, 7'h07);
		serve(8'h0E, 3'h5, 1'b1);
		// Pin held high: edge mode once, level mode again
		@(posedge ref_clk);
		pins <= 4'h4;
		serve(8'h0E, 3'h5, 1'b1);
		tick(4);
		check(8'(pending[5]), 8'h00);
		ctl(3'h5, 1'b0, 3'h5, 1'b1, 1'b0);
		serve(8'h0E, 3'h5, 1'b0);
		@(posedge ref_clk);
		pins <= 4'h0;
		tick(2);
		check(8'(pending[5]), 8'h01);
		wr(2, 7'h05);
		serve(8'h0E, 3'h5, 1'b1);
		// Pin zero serviced again while in service
		ctl(3'h3, 1'b0, 3'h3, 1'b0, 1'b1);
		ev(3'h0, 2'h0, 4'h1);
		serve(8'h0C, 3'h3, 1'b0);
		ev(3'h0, 2'h0, 4'h1);
		serve(8'h0C, 3'h3, 1'b0);
		wr(2, 7'h03);
		tick(1);
		check(8'(in_service), 8'h00);
		// Low enable: a channel event must not be latched
		@(posedge ref_clk);
		clk_en <= 1'b0;
		ev(3'h0, 2'h1, 4'h0);
		@(posedge ref_clk);
		clk_en <= 1'b1;
		tick(2);
		check(8'(pending), 8'h00);
		check(8'(int_req), 8'h00);
		tally_and_finish();
	end

endmodule : tb_iprr_top
